// ==== cassette_pkg.sv ====
// Package for the memory cassette transfer control block.
// Assumes a single APB clock domain; shared by the top and the engine.
package cassette_pkg;

    // ------------------------------------------------------------------
    // Register indices and byte addresses
    // ------------------------------------------------------------------
    localparam logic [11:0] PROG_CTRL_IDX  = 12'h10e;
    localparam logic [11:0] SIZE_RPT_IDX   = 12'h10f;
    localparam logic [11:0] MEM_ERR_IDX    = 12'h110;
    localparam logic [11:0] IO_CTRL_IDX    = 12'h111;
    localparam logic [11:0] CONTENT_IDX    = 12'h10d;
    localparam logic [11:0] MODE_IDX       = 12'h112;
    localparam logic [13:0] PROG_CTRL_ADDR = {PROG_CTRL_IDX, 2'b00};
    localparam logic [13:0] SIZE_RPT_ADDR  = {SIZE_RPT_IDX, 2'b00};
    localparam logic [13:0] MEM_ERR_ADDR   = {MEM_ERR_IDX, 2'b00};
    localparam logic [13:0] IO_CTRL_ADDR   = {IO_CTRL_IDX, 2'b00};
    localparam logic [13:0] CONTENT_ADDR   = {CONTENT_IDX, 2'b00};
    localparam logic [13:0] MODE_ADDR      = {MODE_IDX, 2'b00};

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int SAVE_BIT    = 0;
    localparam int LOAD_BIT    = 1;
    localparam int CMP_BIT     = 2;
    localparam int CMP_RES_BIT = 3;
    localparam int ERR_LINK    = 11;
    localparam int ERR_MODE_P  = 12;
    localparam int ERR_RO_P    = 13;
    localparam int ERR_CAP_P   = 14;
    localparam int ERR_CSUM_P  = 15;
    localparam int ERR_MODE_IO = 12;
    localparam int ERR_RO_IO   = 13;
    localparam int ERR_CAP_IO  = 14;
    localparam int BANK_LSB    = 8;
    localparam int MEMERR_LSB  = 11;

    // ------------------------------------------------------------------
    // Encodings
    // ------------------------------------------------------------------
    localparam logic [1:0] MODE_PROGRAM = 2'h0;
    localparam logic [1:0] MODE_RUN     = 2'h1;
    localparam logic [1:0] MODE_MONITOR = 2'h2;
    localparam logic [7:0] CONTENT_NONE = 8'h00;
    localparam logic [7:0] CONTENT_PROG = 8'h01;
    localparam logic [7:0] CONTENT_IO   = 8'h02;
    localparam logic [7:0] CONTENT_HIST = 8'h03;
    localparam logic [7:0] SIZE_NONE    = 8'h00;
    localparam logic [15:0] ZERO16      = 16'h0000;

    // Operation kinds sent to the engine
    typedef enum logic [2:0] {
        OP_PROG_SAVE = 3'h0,
        OP_PROG_LOAD = 3'h1,
        OP_PROG_CMP  = 3'h2,
        OP_IO_SAVE   = 3'h3,
        OP_IO_LOAD   = 3'h4
    } op_t;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_RUN  = 4'b0010,
        ST_WAIT = 4'b0100,
        ST_DONE = 4'b1000
    } eng_state_t;

endpackage

// ==== cassette_engine.sv ====
// Transfer engine: runs one cassette operation through the media port.
// Assumes the media side answers media_done within finite time.
`timescale 1ns/1ps
module cassette_engine
    import cassette_pkg::*;
(
    // Clock and reset
    input  wire logic             pclk,
    input  wire logic             presetn,
    // Start request from register logic
    input  wire logic             start,
    input  wire cassette_pkg::op_t op,
    // Media port
    output logic                  media_req,
    output logic [2:0]            media_op,
    input  wire logic             media_done,
    input  wire logic             media_mismatch,
    // Completion
    output logic                  done,
    output logic                  mismatch,
    output logic                  busy
);
    import cassette_pkg::*;

    typedef struct packed {
        eng_state_t st;
        logic       req;
        logic [2:0] op;
        logic       done;
        logic       mis;
    } eng_t;

    eng_t s_r;
    eng_t s_nxt;

    // ------------------------------------------------------------------
    // Sequencing
    // ------------------------------------------------------------------
    // One operation at a time; start is ignored while busy
    always_comb begin
        s_nxt      = s_r;
        s_nxt.done = 1'b0;
        case (s_r.st)
            ST_IDLE: begin
                if (start) begin
                    s_nxt.op  = op;
                    s_nxt.req = 1'b1;
                    s_nxt.mis = 1'b0;
                    s_nxt.st  = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (media_done) begin
                    s_nxt.req = 1'b0;
                    s_nxt.mis = media_mismatch;
                    s_nxt.st  = ST_DONE;
                end
            end
            ST_DONE: begin
                s_nxt.done = 1'b1;
                s_nxt.st   = ST_IDLE;
            end
            default: begin
                s_nxt.st = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= '{st: ST_IDLE, req: 1'b0, op: 3'h0, done: 1'b0, mis: 1'b0};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign media_req = s_r.req;
    assign media_op  = s_r.op;
    assign done      = s_r.done;
    assign mismatch  = s_r.mis;
    assign busy      = (s_r.st != ST_IDLE);

endmodule

// ==== cassette_ctrl.sv ====
// Memory cassette transfer control: APB registers and command checking.
// Assumes mode, cassette state and error inputs are synchronous to pclk.
//
// Behaviour
// - Save bit copies program, self-clears
// - Load bit copies cassette in, self-clears
// - Program command outside PROGRAM raises error
// - Compare bit compares program with cassette
// - Compare result bit: 0 match, 1 differ
// - Program transfer error flags bits 11-15
// - Errors except checksum block program save
// - Cassette ladder size in low byte
// - Processor ladder size in high byte
// - Memory error flags bits 11-15
// - Cassette checksum detail not in memory errors
// - I/O save/load in PROGRAM, self-clears
// - I/O command outside PROGRAM signals error
// - Bank number of stored I/O data
// - I/O error flags, bit 15 zero
// - Errors except read-only block I/O save
// - Cassette content type byte reported
`timescale 1ns/1ps
module cassette_ctrl
    import cassette_pkg::*;
(
    // APB slave
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [15:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    // Controller and cassette state
    input  wire logic        link_active,
    input  wire logic        cassette_read_only,
    input  wire logic        prog_cap_short,
    input  wire logic        io_cap_short,
    input  wire logic        board_csum_err,
    input  wire logic [7:0]  cassette_prog_size,
    input  wire logic [7:0]  cpu_prog_size,
    input  wire logic [7:0]  cassette_content,
    input  wire logic [3:0]  cassette_bank,
    input  wire logic [4:0]  mem_err_in,
    // Media port
    output logic             media_req,
    output logic [2:0]       media_op,
    input  wire logic        media_done,
    input  wire logic        media_mismatch,
    // Non-fatal error indication
    output logic             nonfatal_err
);
    import cassette_pkg::*;

    typedef struct packed {
        logic [1:0]  mode;
        logic [15:0] prog;
        logic [15:0] io;
        logic [15:0] size;
        logic [15:0] memerr;
        logic [7:0]  content;
        logic        ready;
        logic [31:0] rdata;
        logic        slverr;
        logic        nferr;
        logic        start;
        op_t         op;
        logic        active;
        logic        is_io;
        logic [2:0]  pend;
    } st_t;

    st_t s_r;
    st_t s_nxt;

    logic eng_done;
    logic eng_mis;
    logic eng_busy;

    // ------------------------------------------------------------------
    // Transfer engine
    // ------------------------------------------------------------------
    cassette_engine u_engine (
        .pclk           (pclk),
        .presetn        (presetn),
        .start          (s_r.start),
        .op             (s_r.op),
        .media_req      (media_req),
        .media_op       (media_op),
        .media_done     (media_done),
        .media_mismatch (media_mismatch),
        .done           (eng_done),
        .mismatch       (eng_mis),
        .busy           (eng_busy)
    );

    // ------------------------------------------------------------------
    // Register and command logic
    // ------------------------------------------------------------------
    logic [13:0] addr_w;
    logic        wr_acc;
    logic        rd_acc;
    logic        in_prog;
    logic        perr_block;
    logic        ierr_block;
    logic [15:0] wd;

    always_comb begin
        s_nxt        = s_r;
        s_nxt.start  = 1'b0;
        s_nxt.ready  = 1'b0;
        s_nxt.slverr = 1'b0;
        s_nxt.nferr  = 1'b0;
        addr_w  = paddr[13:0];
        wd      = pwdata[15:0];
        // Write lands at the access edge, while pready stands; high address bits are refused
        wr_acc  = psel && penable && pwrite && s_r.ready && (paddr[15:14] == 2'b00);
        rd_acc  = psel && !penable && !pwrite && (paddr[15:14] == 2'b00);
        in_prog = (s_r.mode == MODE_PROGRAM);

        // Live status reports
        s_nxt.size    = {cpu_prog_size, cassette_prog_size};
        // Cassette-internal checksum detail never lands here
        s_nxt.memerr  = {mem_err_in, 11'h000};
        s_nxt.content = cassette_content;
        s_nxt.io[BANK_LSB +: 4] = cassette_bank;
        s_nxt.io[15] = 1'b0;

        // Program area commands set by software; bits held while running
        if (wr_acc && addr_w == PROG_CTRL_ADDR && !s_r.active) begin
            s_nxt.prog[CMP_BIT:SAVE_BIT] = wd[CMP_BIT:SAVE_BIT];
            s_nxt.pend = wd[CMP_BIT:SAVE_BIT];
        end
        if (wr_acc && addr_w == IO_CTRL_ADDR && !s_r.active) begin
            // Bit 02 is stored as written; software keeps it zero
            s_nxt.io[CMP_BIT:SAVE_BIT] = wd[CMP_BIT:SAVE_BIT];
            s_nxt.pend = {1'b1, wd[LOAD_BIT:SAVE_BIT]};
            s_nxt.is_io = 1'b1;
        end
        if (wr_acc && addr_w == MODE_ADDR) begin
            s_nxt.mode = wd[1:0];
        end
        if (wr_acc && addr_w == PROG_CTRL_ADDR && !s_r.active) begin
            s_nxt.is_io = 1'b0;
        end

        // Launch one pending command, mode sampled now
        perr_block = link_active || cassette_read_only || prog_cap_short || !in_prog;
        ierr_block = io_cap_short || !in_prog;
        if (!s_r.active && !eng_busy && (s_r.prog[CMP_BIT:SAVE_BIT] != 3'h0)
            && !s_r.is_io) begin
            s_nxt.prog[ERR_LINK]   = link_active;
            s_nxt.prog[ERR_MODE_P] = !in_prog;
            s_nxt.prog[ERR_RO_P]   = cassette_read_only;
            s_nxt.prog[ERR_CAP_P]  = prog_cap_short;
            s_nxt.prog[ERR_CSUM_P] = 1'b0;
            if (s_r.prog[CMP_BIT]) begin
                if (eng_busy) begin
                    s_nxt.active = 1'b0;
                end else if (cassette_content != CONTENT_PROG) begin
                    s_nxt.prog[CMP_RES_BIT] = 1'b1;
                    s_nxt.prog[CMP_BIT]     = 1'b0;
                end else begin
                    s_nxt.op     = OP_PROG_CMP;
                    s_nxt.start  = 1'b1;
                    s_nxt.active = 1'b1;
                end
            end else if (!in_prog) begin
                s_nxt.nferr = 1'b1;
                s_nxt.prog[LOAD_BIT:SAVE_BIT] = 2'b00;
            end else if (s_r.prog[SAVE_BIT] && perr_block) begin
                s_nxt.prog[SAVE_BIT] = 1'b0;
            end else if (s_r.prog[LOAD_BIT] && prog_cap_short) begin
                s_nxt.prog[LOAD_BIT] = 1'b0;
            end else begin
                s_nxt.op     = s_r.prog[SAVE_BIT] ? OP_PROG_SAVE : OP_PROG_LOAD;
                s_nxt.start  = 1'b1;
                s_nxt.active = 1'b1;
            end
        end else if (!s_r.active && !eng_busy && (s_r.io[LOAD_BIT:SAVE_BIT] != 2'b00)
                     && s_r.is_io) begin
            s_nxt.io[ERR_MODE_IO] = !in_prog;
            s_nxt.io[ERR_RO_IO]   = cassette_read_only;
            s_nxt.io[ERR_CAP_IO]  = io_cap_short;
            if (!in_prog) begin
                s_nxt.nferr = 1'b1;
                s_nxt.io[LOAD_BIT:SAVE_BIT] = 2'b00;
            end else if (ierr_block) begin
                s_nxt.io[LOAD_BIT:SAVE_BIT] = 2'b00;
            end else begin
                s_nxt.op     = s_r.io[SAVE_BIT] ? OP_IO_SAVE : OP_IO_LOAD;
                s_nxt.start  = 1'b1;
                s_nxt.active = 1'b1;
            end
        end

        // Completion: clear the command bit, record outcome
        if (s_r.active && eng_done) begin
            s_nxt.active = 1'b0;
            case (s_r.op)
                OP_PROG_SAVE: begin
                    s_nxt.prog[SAVE_BIT]   = 1'b0;
                    s_nxt.prog[ERR_CSUM_P] = board_csum_err;
                end
                OP_PROG_LOAD: begin
                    s_nxt.prog[LOAD_BIT]   = 1'b0;
                    s_nxt.prog[ERR_CSUM_P] = board_csum_err;
                end
                OP_PROG_CMP: begin
                    s_nxt.prog[CMP_BIT]     = 1'b0;
                    s_nxt.prog[CMP_RES_BIT] = eng_mis;
                end
                OP_IO_SAVE: begin
                    s_nxt.io[SAVE_BIT] = 1'b0;
                end
                OP_IO_LOAD: begin
                    s_nxt.io[LOAD_BIT] = 1'b0;
                end
                default: begin
                    s_nxt.active = 1'b0;
                end
            endcase
        end

        // APB: setup decodes, access completes next cycle
        if (rd_acc) begin
            case (addr_w)
                PROG_CTRL_ADDR: s_nxt.rdata = {16'h0000, s_r.prog};
                SIZE_RPT_ADDR:  s_nxt.rdata = {16'h0000, s_r.size};
                MEM_ERR_ADDR:   s_nxt.rdata = {16'h0000, s_r.memerr};
                IO_CTRL_ADDR:   s_nxt.rdata = {16'h0000, s_r.io};
                CONTENT_ADDR:   s_nxt.rdata = {24'h000000, s_r.content};
                MODE_ADDR:      s_nxt.rdata = {30'h0, s_r.mode};
                default:        s_nxt.rdata = 32'h00000000;
            endcase
        end else if (psel && !penable) begin
            // Writes and refused reads return zero, never stale read data
            s_nxt.rdata = 32'h00000000;
        end
        if (psel && !penable) begin
            s_nxt.ready  = 1'b1;
            s_nxt.slverr = !(addr_w == PROG_CTRL_ADDR || addr_w == SIZE_RPT_ADDR ||
                             addr_w == MEM_ERR_ADDR || addr_w == IO_CTRL_ADDR ||
                             addr_w == CONTENT_ADDR || addr_w == MODE_ADDR) ||
                           (paddr[15:14] != 2'b00);
        end
    end

    // Single register bank for all state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign pready       = s_r.ready;
    assign prdata       = s_r.rdata;
    assign pslverr      = s_r.slverr;
    assign nonfatal_err = s_r.nferr;

endmodule

// ==== cassette_ctrl_sva.sv ====
// Checker for the cassette control block: APB timing, media handshake, word shape.
// Assumes it is bound to cassette_ctrl and sees only that module's ports.
`timescale 1ns/1ps
module cassette_ctrl_chk
    import cassette_pkg::*;
(
    // Clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // APB
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [15:0] paddr,
    input wire logic        pready,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    // Media port and error
    input wire logic        media_req,
    input wire logic [2:0]  media_op,
    input wire logic        media_done,
    input wire logic        nonfatal_err
);
    logic mapped;

    // Decoded register map, used to spot unmapped accesses
    assign mapped = paddr inside {PROG_CTRL_ADDR, SIZE_RPT_ADDR, MEM_ERR_ADDR,
                                  IO_CTRL_ADDR, CONTENT_ADDR, MODE_ADDR};

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // ------------------------------------------------------------
    // Bus answer
    // ------------------------------------------------------------
    pready_setup_a: assert property (psel && !penable |=> pready)
        else $error("pready missing after setup");
    pready_pulse_a: assert property (pready |=> !pready)
        else $error("pready held too long");
    slverr_map_a: assert property (psel && !penable && !mapped |=> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    upper_zero_a: assert property (pready |-> prdata[31:16] == 16'h0)
        else $error("upper read half not zero");
    io_top_a: assert property (pready && !pwrite && paddr == IO_CTRL_ADDR |-> !prdata[15])
        else $error("io word bit 15 set");
    memerr_low_a: assert property (pready && !pwrite && paddr == MEM_ERR_ADDR |-> prdata[10:0] == 11'h0)
        else $error("memory error low bits set");

    // ------------------------------------------------------------
    // Media handshake and error pulse
    // ------------------------------------------------------------
    req_hold_a: assert property (media_req && !media_done |=> media_req)
        else $error("media request dropped early");
    req_drop_a: assert property (media_req && media_done |-> ##[1:3] !media_req)
        else $error("media request not released");
    op_stable_a: assert property (media_req && $past(media_req) |-> $stable(media_op))
        else $error("media op changed mid operation");
    op_legal_a: assert property (media_req |-> media_op <= 3'h4)
        else $error("illegal media op");
    err_pulse_a: assert property (nonfatal_err |=> !nonfatal_err)
        else $error("error pulse too long");
endmodule

bind cassette_ctrl cassette_ctrl_chk u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .media_req(media_req), .media_op(media_op), .media_done(media_done),
    .nonfatal_err(nonfatal_err)
);

// ==== cassette_media_model.sv ====
// Behavioural cassette: answers each media request after a chosen delay.
// Assumes media_req stays high until media_done has been seen.
`timescale 1ns/1ps
module cassette_media_model (
    // Clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // Request side
    input  wire logic       media_req,
    input  wire logic [2:0] media_op,
    // Behaviour knobs from the bench
    input  wire logic [7:0] delay,
    input  wire logic       mis_set,
    // Answer
    output logic            media_done,
    output logic            media_mismatch
);
    int   cnt;
    logic served;

    // One answer per request; mismatch toggles outside done so it is never trusted
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt            <= 0;
            served         <= 1'b0;
            media_done     <= 1'b0;
            media_mismatch <= 1'b0;
        end else begin
            media_done     <= 1'b0;
            media_mismatch <= ~media_mismatch;
            if (!media_req) begin
                served <= 1'b0;
                cnt    <= 0;
            end else if (!served) begin
                if (cnt >= int'(delay)) begin
                    media_done     <= 1'b1;
                    media_mismatch <= mis_set;
                    served         <= 1'b1;
                end else begin
                    cnt <= cnt + 1;
                end
            end
        end
    end
endmodule

// ==== tb_memory_cassette_transfer_control.sv ====
// Self-checking bench for the cassette control block.
// Assumes the cassette_pkg map and the behavioural media model.
`timescale 1ns/1ps
module tb_memory_cassette_transfer_control;
    import cassette_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, lerr, req_q;
    logic [15:0] paddr;
    logic [31:0] pwdata, prdata, last;
    logic        link_active, cassette_read_only, prog_cap_short, io_cap_short, board_csum_err;
    logic [7:0]  cassette_prog_size, cpu_prog_size, cassette_content, delay;
    logic [3:0]  cassette_bank;
    logic [4:0]  mem_err_in;
    logic        media_req, media_done, media_mismatch, nonfatal_err, mis_set;
    logic [2:0]  media_op;
    int          miscompares, num_checks, err_pulses, p0;
    int          seen[$];

    cassette_ctrl DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .link_active(link_active), .cassette_read_only(cassette_read_only),
        .prog_cap_short(prog_cap_short), .io_cap_short(io_cap_short),
        .board_csum_err(board_csum_err), .cassette_prog_size(cassette_prog_size),
        .cpu_prog_size(cpu_prog_size), .cassette_content(cassette_content),
        .cassette_bank(cassette_bank), .mem_err_in(mem_err_in), .media_req(media_req),
        .media_op(media_op), .media_done(media_done), .media_mismatch(media_mismatch),
        .nonfatal_err(nonfatal_err));
    cassette_media_model u_media (.pclk(pclk), .presetn(presetn), .media_req(media_req),
        .media_op(media_op), .delay(delay), .mis_set(mis_set), .media_done(media_done),
        .media_mismatch(media_mismatch));

    // Clock
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    // Monitor: records each launched operation and each error pulse
    always @(posedge pclk) begin
        if (media_req === 1'b1 && req_q !== 1'b1) seen.push_back(int'(media_op));
        if (nonfatal_err === 1'b1) err_pulses++;
        req_q <= media_req;
    end

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    // One APB transfer; the idle edge afterwards keeps drivers single per step
    task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1);
        chk("pready wait", 32'h1, 32'(n));
        last = prdata;
        lerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    // Set a command bit, poll until it clears, compare launches with exp_op
    task automatic cmd(input logic [15:0] a, input int b, input int exp_op, input string nm);
        int n, s0;
        s0 = seen.size();
        apb(1'b1, a, 32'h1 << b);
        n = 0;
        do begin
            apb(1'b0, a, 32'h0);
            n++;
        end while (last[b] !== 1'b0 && n < 60);
        chk({nm, " bit clear"}, 32'h0, {31'h0, last[b]});
        chk({nm, " launches"}, (exp_op < 0) ? 0 : 1, seen.size() - s0);
        if (exp_op >= 0 && seen.size() > s0) chk({nm, " op"}, exp_op, seen[$]);
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Watchdog
    initial begin
        repeat (20000) @(posedge pclk);
        miscompares++;
        print_verdict();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, mis_set} = '0;
        {link_active, cassette_read_only, prog_cap_short, io_cap_short, board_csum_err} = '0;
        {cassette_prog_size, cpu_prog_size, cassette_content, cassette_bank, mem_err_in} = '0;
        delay = 8'h00;
        void'($urandom(9));
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        cassette_prog_size <= 8'($urandom);
        cpu_prog_size <= 8'($urandom);
        mem_err_in <= 5'($urandom);
        cassette_bank <= 4'($urandom);
        cassette_content <= CONTENT_IO;
        repeat (3) @(posedge pclk);
        apb(1'b0, SIZE_RPT_ADDR, 32'h0);
        chk("size word", {16'h0, cpu_prog_size, cassette_prog_size}, last);
        apb(1'b0, MEM_ERR_ADDR, 32'h0);
        chk("memory errors", {16'h0, mem_err_in, 11'h0}, last);
        apb(1'b0, IO_CTRL_ADDR, 32'h0);
        chk("bank number", {28'h0, cassette_bank}, {28'h0, last[11:8]});
        apb(1'b0, CONTENT_ADDR, 32'h0);
        chk("content type", {24'h0, cassette_content}, last);
        apb(1'b0, 16'h0500, 32'h0);
        chk("unmapped refusal", 32'h1, {31'h0, lerr});
        // Every command code, prompt and slow cassette
        cassette_content <= CONTENT_PROG;
        for (int i = 0; i < 5; i++) begin
            delay <= 8'(i * 3);
            mis_set <= 1'($urandom);
            @(posedge pclk);
            cmd((i < 3) ? 16'(PROG_CTRL_ADDR) : 16'(IO_CTRL_ADDR), (i < 3) ? i : i - 3, i,
                "command");
            if (i == 2) chk("compare result", {31'h0, mis_set}, {31'h0, last[CMP_RES_BIT]});
        end
        cassette_content <= CONTENT_IO;
        cmd(PROG_CTRL_ADDR, CMP_BIT, -1, "compare without program");
        chk("compare not possible", 32'h1, {31'h0, last[CMP_RES_BIT]});
        // Wrong operating mode
        for (int m = 1; m < 3; m++) begin
            apb(1'b1, MODE_ADDR, 32'(m));
            p0 = err_pulses;
            cmd(PROG_CTRL_ADDR, SAVE_BIT, -1, "save wrong mode");
            chk("program mode flag", 32'h1, {31'h0, last[ERR_MODE_P]});
            cmd(IO_CTRL_ADDR, LOAD_BIT, -1, "io load wrong mode");
            chk("io mode flag", 32'h1, {31'h0, last[ERR_MODE_IO]});
            chk("error pulses", p0 + 2, err_pulses);
        end
        apb(1'b1, MODE_ADDR, 32'(MODE_PROGRAM));
        // Error conditions one at a time
        link_active <= 1'b1;
        cmd(PROG_CTRL_ADDR, SAVE_BIT, -1, "save during link");
        chk("link flag", 32'h1, {31'h0, last[ERR_LINK]});
        link_active <= 1'b0;
        cassette_read_only <= 1'b1;
        cmd(PROG_CTRL_ADDR, SAVE_BIT, -1, "save read only");
        chk("read only flag", 32'h1, {31'h0, last[ERR_RO_P]});
        cmd(IO_CTRL_ADDR, SAVE_BIT, 3, "io save read only");
        cassette_read_only <= 1'b0;
        prog_cap_short <= 1'b1;
        cmd(PROG_CTRL_ADDR, LOAD_BIT, -1, "load short");
        chk("capacity flag", 32'h1, {31'h0, last[ERR_CAP_P]});
        prog_cap_short <= 1'b0;
        io_cap_short <= 1'b1;
        cmd(IO_CTRL_ADDR, SAVE_BIT, -1, "io save short");
        chk("io capacity flag", 32'h1, {31'h0, last[ERR_CAP_IO]});
        io_cap_short <= 1'b0;
        board_csum_err <= 1'b1;
        cmd(PROG_CTRL_ADDR, SAVE_BIT, 0, "save checksum");
        chk("checksum flag", 32'h1, {31'h0, last[ERR_CSUM_P]});
        board_csum_err <= 1'b0;
        cmd(PROG_CTRL_ADDR, SAVE_BIT, 0, "save retried");
        print_verdict();
    end
endmodule
